// ---- src/chain_seq_pkg.sv ----
// Constants, encodings and carrier types of the operation chain sequencer.
// Assumes a 125 MHz system clock and a classic Wishbone register port.
package chain_seq_pkg;

    // Clock period and one dwell step, in nanoseconds.
    localparam int CLK_NS = 8;
    localparam int MS_NS  = 1000000;
    localparam int MS_CYC = MS_NS / CLK_NS;

    // Byte addresses of the register map.
    localparam logic [9:0] ADR_TABLE = 10'h000;
    localparam logic [9:0] ADR_SPEED = 10'h100;
    localparam logic [9:0] ADR_CTRL  = 10'h200;
    localparam logic [9:0] ADR_STAT  = 10'h204;

    // Entry word field positions.
    localparam int FN_LSB    = 0;
    localparam int DIR_BIT   = 2;
    localparam int DWELL_LSB = 4;
    localparam int ACC_LSB   = 16;
    localparam int DEC_LSB   = 24;

    // Control and status bit positions.
    localparam int CTRL_CLR_BIT = 0;
    localparam int STAT_CUR_LSB = 8;

    // Reset values and limits.
    localparam logic [31:0] ENTRY_RST  = 32'h0000_0000;
    localparam logic [7:0]  SPEED_RST  = 8'h00;
    localparam logic [5:0]  LAST_ENTRY = 6'h3F;
    localparam logic [2:0]  MAX_CHAIN  = 3'h4;

    // Operation function of an entry.
    typedef enum logic [1:0] {
        FN_SINGLE = 2'h0,
        FN_LINK   = 2'h1,
        FN_LINK2  = 2'h2,
        FN_PUSH   = 2'h3
    } func_t;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SCAN  = 4'h2,
        ST_RUN   = 4'h4,
        ST_DWELL = 4'h8
    } state_t;

    // Segment command handed to the positioning engine.
    typedef struct packed {
        logic       go;
        logic       link;
        logic [5:0] entry;
        logic       dir;
        logic [7:0] accel;
        logic [7:0] decel;
        logic [7:0] speed;
    } seg_cmd_t;

    // Whole state of the sequencer.
    typedef struct packed {
        state_t     st;
        logic [5:0] first;
        logic [5:0] cur;
        logic [2:0] cnt;
        logic [7:0] acc;
        logic [7:0] dec;
        logic [31:0] pre;
        logic [11:0] dwell;
        logic       ready;
        logic       move;
        logic       alarm;
        seg_cmd_t   cmd;
        logic       ack;
        logic [31:0] dat;
    } regs_t;

endpackage : chain_seq_pkg

// ---- src/operation_data_chain_sequencer.sv ----
// Operation chain sequencer: runs single, linked and dwell-linked moves
// from a 64-entry table held here and written over Wishbone.
// Assumes a positioning engine that takes seg_o and pulses seg_done_i.
//
// Operation
// RULE1 - A single-motion entry makes exactly one move, then stops.
// RULE2 - A linked-motion entry flows into the next entry without stopping.
// RULE3 - A chain ends at the first single-motion or push entry.
// RULE4 - Five or more chained entries raise the data alarm at start.
// RULE5 - Plain linked entries of differing direction raise the alarm.
// RULE6 - Entry 63 never chains onward to entry 0.
// RULE7 - A plain chain keeps the rates of its first entry.
// RULE8 - A final push entry starts at its push speed.
// RULE9 - Dwell-linked entries may reverse, halting for the dwell time.
// RULE10 - The table owner keeps mixed chains at four entries or fewer.
// RULE11 - Host checks ready, sets the entry number, then asserts start.
// RULE12 - Host releases start only after seeing ready low.
// RULE13 - Ready falls when an operation begins, rises when it ends.
// RULE14 - Motion output is low from segment end through the dwell.
// RULE15 - After the dwell the next entry starts with motion output high.
// RULE16 - Ready stays low through every dwell until the chain ends.
// RULE17 - Entries are numbered 0 to 63 on six select lines.
// RULE18 - Select lines are set before start is asserted.
// RULE19 - Motion output is high exactly while a segment runs.
// RULE20 - Dwell is counted in milliseconds from segment completion.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module operation_data_chain_sequencer #(
    parameter int CYCLES_PER_MS = chain_seq_pkg::MS_CYC
) (
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone slave.
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [9:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic                         wb_ack_o,
    output logic [31:0]                  wb_dat_o,
    // Host inputs.
    input  wire logic [5:0]              entry_select_lines_i,
    input  wire logic                    start_i,
    // Host outputs.
    output logic                         ready_o,
    output logic                         move_o,
    output logic                         alarm_o,
    // Positioning engine.
    output chain_seq_pkg::seg_cmd_t      seg_o,
    input  wire logic                    seg_done_i
);

    // A ms prescaler shorter than two cycles cannot time a dwell.
    if (CYCLES_PER_MS < 2) begin : g_chk
        $error("CYCLES_PER_MS must be at least 2");
    end

    localparam logic [31:0] PRE_TOP = 32'(CYCLES_PER_MS - 1);

    logic [31:0]          tab [64];
    logic [7:0]           spd [64];
    chain_seq_pkg::regs_t r;
    chain_seq_pkg::regs_t next_r;
    logic                 bus_req;
    logic                 bus_wr;

    // Function field of an entry word.
    function automatic chain_seq_pkg::func_t fn_of(input logic [31:0] w);
        return chain_seq_pkg::func_t'(w[chain_seq_pkg::FN_LSB +: 2]);
    endfunction : fn_of

    // True when an entry passes on to the following entry.
    function automatic logic links(input logic [31:0] w,
                                   input logic [5:0]  e);
        return (fn_of(w) == chain_seq_pkg::FN_LINK ||
                fn_of(w) == chain_seq_pkg::FN_LINK2) &&
               e != chain_seq_pkg::LAST_ENTRY; // RULE6
    endfunction : links

    // Builds the segment command for one entry.
    function automatic chain_seq_pkg::seg_cmd_t mk_cmd(
        input logic [5:0]  e,
        input logic [31:0] w,
        input logic [7:0]  s,
        input logic        lk,
        input logic [7:0]  ac,
        input logic [7:0]  dc
    );
        chain_seq_pkg::seg_cmd_t c;
        c.go    = 1'b1;
        c.link  = lk;
        c.entry = e;
        c.dir   = w[chain_seq_pkg::DIR_BIT];
        c.accel = ac;
        c.decel = dc;
        // A push segment starts straight at its push speed.
        c.speed = (fn_of(w) == chain_seq_pkg::FN_PUSH) ? s : 8'h00; // RULE8
        return c;
    endfunction : mk_cmd

    assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;
    assign bus_wr  = bus_req && wb_we_i;

    // Table storage; byte lanes follow sel, the speed array uses lane 0.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 64; i++) begin
                tab[i] <= chain_seq_pkg::ENTRY_RST;
                spd[i] <= chain_seq_pkg::SPEED_RST;
            end
        end else if (bus_wr && wb_adr_i[9:8] == 2'h0) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    tab[wb_adr_i[7:2]][8*b +: 8] <= wb_dat_i[8*b +: 8];
                end
            end
        end else if (bus_wr && wb_adr_i[9:8] == 2'h1 && wb_sel_i[0]) begin
            spd[wb_adr_i[7:2]] <= wb_dat_i[7:0];
        end
    end

    // Next-state logic for the bus slave and the sequencer.
    always_comb begin
        logic [31:0] w;
        logic [5:0]  nx;
        w      = tab[r.cur];
        nx     = r.cur + 6'h01;
        next_r = r;
        next_r.cmd.go = 1'b0;
        next_r.ack    = bus_req;
        next_r.dat    = 32'h0000_0000;

        // Register reads; unmapped addresses read zero and are acked.
        if (wb_adr_i[9:8] == 2'h0) begin
            next_r.dat = tab[wb_adr_i[7:2]];
        end else if (wb_adr_i[9:8] == 2'h1) begin
            next_r.dat = {24'h00_0000, spd[wb_adr_i[7:2]]};
        end else if (wb_adr_i == chain_seq_pkg::ADR_STAT) begin
            next_r.dat = {18'h0_0000, r.cur, r.st, 1'b0,
                          r.alarm, r.move, r.ready};
        end

        // Alarm clear; any alarm raised below in this cycle still wins.
        if (bus_wr && wb_adr_i == chain_seq_pkg::ADR_CTRL &&
            wb_sel_i[0] && wb_dat_i[chain_seq_pkg::CTRL_CLR_BIT]) begin
            next_r.alarm = 1'b0;
        end

        case (r.st)
            chain_seq_pkg::ST_IDLE: begin
                next_r.move  = 1'b0;
                next_r.ready = !next_r.alarm;
                // The host holds start until it sees ready fall.
                if (start_i && r.ready) begin // RULE11
                    next_r.ready = 1'b0; // RULE13
                    next_r.first = entry_select_lines_i; // RULE17
                    next_r.cur   = entry_select_lines_i;
                    next_r.cnt   = 3'h1;
                    next_r.st    = chain_seq_pkg::ST_SCAN;
                end
            end
            chain_seq_pkg::ST_SCAN: begin
                // Walk the chain before moving so that an overlong
                // chain is refused without any motion at all.
                if (links(w, r.cur)) begin
                    if (r.cnt == chain_seq_pkg::MAX_CHAIN) begin
                        next_r.alarm = 1'b1; // RULE4
                        next_r.st    = chain_seq_pkg::ST_IDLE;
                    end else begin
                        next_r.cur = nx;
                        next_r.cnt = r.cnt + 3'h1;
                    end
                end else begin
                    next_r.cur  = r.first;
                    next_r.acc  = tab[r.first][chain_seq_pkg::ACC_LSB +: 8];
                    next_r.dec  = tab[r.first][chain_seq_pkg::DEC_LSB +: 8];
                    next_r.cmd  = mk_cmd(r.first, tab[r.first],
                                         spd[r.first], 1'b0,
                                         next_r.acc, next_r.dec);
                    next_r.move = 1'b1; // RULE19
                    next_r.st   = chain_seq_pkg::ST_RUN;
                end
            end
            chain_seq_pkg::ST_RUN: begin
                if (seg_done_i) begin
                    if (links(w, r.cur) &&
                        fn_of(w) == chain_seq_pkg::FN_LINK) begin
                        if (tab[nx][chain_seq_pkg::DIR_BIT] !=
                            w[chain_seq_pkg::DIR_BIT]) begin
                            next_r.alarm = 1'b1; // RULE5
                            next_r.move  = 1'b0;
                            next_r.st    = chain_seq_pkg::ST_IDLE;
                        end else begin
                            // No stop: the engine blends into the next.
                            next_r.cur = nx; // RULE2
                            next_r.cmd = mk_cmd(nx, tab[nx], spd[nx],
                                                1'b1, r.acc,
                                                r.dec); // RULE7
                        end
                    end else if (links(w, r.cur)) begin
                        next_r.move  = 1'b0; // RULE14
                        next_r.pre   = 32'h0000_0000;
                        next_r.dwell =
                            w[chain_seq_pkg::DWELL_LSB +: 12]; // RULE20
                        next_r.st    = chain_seq_pkg::ST_DWELL; // RULE9
                    end else begin
                        // Single or push entry closes the operation.
                        next_r.move = 1'b0; // RULE1 RULE3
                        next_r.st   = chain_seq_pkg::ST_IDLE;
                    end
                end
            end
            chain_seq_pkg::ST_DWELL: begin // RULE16
                // Ready stays low here; idle is the only place it rises.
                if (r.dwell == 12'h000) begin
                    next_r.cur  = nx;
                    next_r.acc  = tab[nx][chain_seq_pkg::ACC_LSB +: 8];
                    next_r.dec  = tab[nx][chain_seq_pkg::DEC_LSB +: 8];
                    next_r.cmd  = mk_cmd(nx, tab[nx], spd[nx], 1'b0,
                                         next_r.acc, next_r.dec);
                    next_r.move = 1'b1; // RULE15
                    next_r.st   = chain_seq_pkg::ST_RUN;
                end else if (r.pre == PRE_TOP) begin
                    next_r.pre   = 32'h0000_0000;
                    next_r.dwell = r.dwell - 12'h001; // RULE20
                end else begin
                    next_r.pre = r.pre + 32'h0000_0001;
                end
            end
            default: begin
                next_r.st = chain_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // State register; ready comes up one cycle after reset release.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r       <= '0;
            r.st    <= chain_seq_pkg::ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.dat;
    assign ready_o  = r.ready;
    assign move_o   = r.move;
    assign alarm_o  = r.alarm;
    assign seg_o    = r.cmd;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ready_on_start_a: assert property ( // RULE13
        r.st == chain_seq_pkg::ST_IDLE && start_i && r.ready
        |=> !ready_o ##1 !ready_o)
        else $error("ready did not fall on start");

    ready_idle_a: assert property ( // RULE16
        ready_o |-> r.st == chain_seq_pkg::ST_IDLE && !alarm_o)
        else $error("ready high outside idle");

    move_dwell_a: assert property ( // RULE14
        r.st == chain_seq_pkg::ST_DWELL |-> !move_o)
        else $error("move high during dwell");

    dwell_start_a: assert property ( // RULE15
        r.st == chain_seq_pkg::ST_DWELL && r.dwell == 12'h000
        |=> seg_o.go && move_o && seg_o.entry == $past(r.cur) + 6'h01)
        else $error("next entry not started after dwell");

    chain_limit_a: assert property ( // RULE4
        r.st == chain_seq_pkg::ST_SCAN && links(tab[r.cur], r.cur) &&
        r.cnt == chain_seq_pkg::MAX_CHAIN
        |=> alarm_o && !move_o ##1 !seg_o.go)
        else $error("overlong chain not refused");

    link_rates_a: assert property ( // RULE7
        seg_o.go && seg_o.link |-> seg_o.accel == r.acc &&
        seg_o.decel == r.dec && $stable(r.acc))
        else $error("linked segment changed rates");

    last_entry_a: assert property ( // RULE6
        r.st == chain_seq_pkg::ST_RUN && seg_done_i &&
        r.cur == chain_seq_pkg::LAST_ENTRY
        |=> r.st == chain_seq_pkg::ST_IDLE && !seg_o.go)
        else $error("entry 63 chained onward");

    single_stop_a: assert property ( // RULE1
        r.st == chain_seq_pkg::ST_RUN && seg_done_i &&
        fn_of(tab[r.cur]) == chain_seq_pkg::FN_SINGLE
        |=> !move_o ##1 ready_o || alarm_o)
        else $error("single entry did not stop");

    dir_err_a: assert property ( // RULE5
        r.st == chain_seq_pkg::ST_RUN && seg_done_i &&
        fn_of(tab[r.cur]) == chain_seq_pkg::FN_LINK &&
        r.cur != chain_seq_pkg::LAST_ENTRY &&
        tab[r.cur + 6'h01][chain_seq_pkg::DIR_BIT] !=
        tab[r.cur][chain_seq_pkg::DIR_BIT]
        |=> alarm_o && !move_o)
        else $error("direction change not flagged");

    push_speed_a: assert property ( // RULE8
        seg_o.go && fn_of(tab[seg_o.entry]) == chain_seq_pkg::FN_PUSH
        |-> seg_o.speed == spd[seg_o.entry])
        else $error("push speed not applied");

    // Motion output follows the run state exactly, never a dwell or idle.
    move_run_a: assert property ( // RULE19
        move_o == (r.st == chain_seq_pkg::ST_RUN))
        else $error("move output outside a running segment");

    // A plain link of equal direction must blend without a standstill.
    link_blend_a: assert property ( // RULE2
        r.st == chain_seq_pkg::ST_RUN && seg_done_i &&
        fn_of(tab[r.cur]) == chain_seq_pkg::FN_LINK &&
        r.cur != chain_seq_pkg::LAST_ENTRY &&
        tab[r.cur + 6'h01][chain_seq_pkg::DIR_BIT] ==
        tab[r.cur][chain_seq_pkg::DIR_BIT]
        |=> seg_o.go && seg_o.link && move_o && !ready_o)
        else $error("linked entry stopped the motor");

    // The dwell count must come from the finished entry's own setting.
    dwell_load_a: assert property ( // RULE20
        r.st == chain_seq_pkg::ST_RUN && seg_done_i &&
        fn_of(tab[r.cur]) == chain_seq_pkg::FN_LINK2 &&
        r.cur != chain_seq_pkg::LAST_ENTRY
        |=> r.st == chain_seq_pkg::ST_DWELL && !move_o &&
        r.dwell == $past(tab[r.cur][chain_seq_pkg::DWELL_LSB +: 12]))
        else $error("dwell not loaded at segment end");

    // One millisecond step is taken only when the prescaler wraps.
    dwell_step_a: assert property ( // RULE20
        r.st == chain_seq_pkg::ST_DWELL && r.dwell != 12'h000 &&
        r.pre == PRE_TOP
        |=> r.pre == 32'h0000_0000 &&
        r.dwell == $past(r.dwell) - 12'h001)
        else $error("dwell step out of time");

endmodule : operation_data_chain_sequencer
`default_nettype wire

// ---- verification/chain_host_model.sv ----
// Host controller model: picks an entry on the select lines and pulses start.
// Assumes ready_i comes from the sequencer in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module chain_host_model (
    // Clock and status from the sequencer.
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    // Command lines to the sequencer.
    output logic [5:0]      entry_select_lines_o,
    output logic            start_o
);
    // Idle command lines from time zero.
    initial begin
        entry_select_lines_o = 6'h00;
        start_o = 1'b0;
    end

    // One command; the number settles a cycle before start so that the
    // sequencer never samples a half-changed selection.
    task automatic command(input logic [5:0] n, output bit ok);
        int w;
        w = 0;
        while (ready_i !== 1'b1 && w < 3000) begin
            @(posedge clk_i);
            w++;
        end
        entry_select_lines_o <= n;
        @(posedge clk_i);
        start_o <= 1'b1;
        @(posedge clk_i);
        while (ready_i !== 1'b0 && w < 3000) begin
            @(posedge clk_i);
            w++;
        end
        start_o <= 1'b0;
        ok = (w < 3000);
    endtask : command
endmodule : chain_host_model
`default_nettype wire

// ---- verification/operation_data_chain_sequencer_tb.sv ----
// Self-checking bench of the chain sequencer with a table-driven model.
// Assumes the host model and a simple engine answering each segment.
`timescale 1ns/1ns
`default_nettype none
module operation_data_chain_sequencer_tb;
    localparam int CPM = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic wb_ack_o, ready_o, move_o, alarm_o, start_i;
    logic [31:0] wb_dat_o;
    logic [5:0] sel_lines;
    logic seg_done_i = 1'b0;
    chain_seq_pkg::seg_cmd_t seg_o;
    chain_seq_pkg::seg_cmd_t exp_q[$];
    int gap_q[$];
    int fn[64], dr[64], dw[64], ac[64], dc[64], sp[64];
    int miscompares = 0;
    int total_checks = 0;
    int eng = 0;
    int gap = 0;
    int mlo = 0;
    logic [15:0] rnd = 16'hC487;
    logic [31:0] rd;
    bit ok;

    chain_host_model host (.clk_i(clk_i), .ready_i(ready_o),
        .entry_select_lines_o(sel_lines), .start_o(start_i));

    operation_data_chain_sequencer #(.CYCLES_PER_MS(CPM)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .entry_select_lines_i(sel_lines),
        .start_i(start_i), .ready_o(ready_o), .move_o(move_o),
        .alarm_o(alarm_o), .seg_o(seg_o), .seg_done_i(seg_done_i));

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Classic single cycle; the request holds until ack is sampled high.
    task automatic wb(input logic we, input logic [9:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int w;
        w = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk_i);
            w++;
        end while (wb_ack_o !== 1'b1 && w < 100);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        check(32'(w < 100), 32'h1);
    endtask : wb

    // Writes one entry and its push speed, keeping the model in step.
    task automatic set_entry(input int n, f, d, w, s);
        logic [31:0] q;
        fn[n] = f;
        dr[n] = d;
        dw[n] = w;
        rnd = lfsr(rnd);
        ac[n] = rnd[7:0];
        dc[n] = rnd[15:8];
        sp[n] = s;
        wb(1'b1, 10'(n * 4), {rnd, 12'(w), 1'b0, 1'(d), 2'(f)}, q);
        wb(1'b1, chain_seq_pkg::ADR_SPEED + 10'(n * 4), 32'(s), q);
    endtask : set_entry

    // Predicts the segments of a start, commands it and checks the end.
    task automatic run(input int s);
        int cnt, e, a, c, t;
        bit al;
        chain_seq_pkg::seg_cmd_t x;
        cnt = 1;
        while ((fn[s+cnt-1] == 1 || fn[s+cnt-1] == 2) && s + cnt - 1 != 63
               && cnt <= 4) cnt++;
        al = (cnt > 4);
        a = ac[s];
        c = dc[s];
        for (int i = 0; i < cnt && !al; i++) begin
            e = s + i;
            if (i > 0 && fn[e-1] == 2) begin
                a = ac[e];
                c = dc[e];
            end
            if (i > 0 && fn[e-1] == 1 && dr[e] != dr[e-1]) begin
                al = 1'b1;
                break;
            end
            x = '{1'b1, 1'(i > 0 && fn[e-1] == 1), 6'(e), 1'(dr[e]),
                  8'(a), 8'(c), 8'(fn[e] == 3 ? sp[e] : 0)};
            exp_q.push_back(x);
            gap_q.push_back(i == 0 ? 0 : fn[e-1] == 2 ? dw[e-1]*CPM+3 : 2);
        end
        host.command(6'(s), ok);
        check(32'(ok), 32'h1);
        for (t = 0; t < 3000 && ready_o !== 1'b1 && alarm_o !== 1'b1;
             t++) @(posedge clk_i);
        check(32'(t < 3000), 32'h1);
        check(ready_o, 32'(!al));
        check(alarm_o, 32'(al));
        check(32'(exp_q.size()), 32'h0);
        check(move_o, 32'h0);
        if (al) begin
            wb(1'b1, chain_seq_pkg::ADR_CTRL, 32'h1, rd);
            repeat (2) @(posedge clk_i);
            check(alarm_o, 32'h0);
        end
    endtask : run

    // Engine stand-in and segment monitor; done follows each go after a
    // random delay, and dwell gaps are counted from done.
    always @(posedge clk_i) begin
        seg_done_i <= 1'b0;
        gap <= gap + 1;
        if (move_o === 1'b0) mlo <= mlo + 1;
        if (eng > 0) eng <= eng - 1;
        if (eng == 1) begin
            seg_done_i <= 1'b1;
            gap <= 1;
            mlo <= 0;
        end
        if (seg_o.go === 1'b1) begin
            rnd = lfsr(rnd);
            eng <= 2 + int'(rnd[1:0]);
            check(32'(exp_q.size() > 0), 32'h1);
            if (exp_q.size() > 0) begin
                check(seg_o.entry, exp_q[0].entry);
                check(seg_o.link, exp_q[0].link);
                check(seg_o.dir, exp_q[0].dir);
                check({seg_o.accel, seg_o.decel},
                      {exp_q[0].accel, exp_q[0].decel});
                check(seg_o.speed, exp_q[0].speed);
                if (gap_q[0] > 0) check(gap, gap_q[0]);
                if (gap_q[0] == 2) check(mlo, 32'h0);
                if (gap_q[0] > 2) check(mlo, gap_q[0] - 2);
                check(move_o, 32'h1);
                check(ready_o, 32'h0);
                void'(exp_q.pop_front());
                void'(gap_q.pop_front());
            end
        end
    end

    // Hang guard.
    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        check(ready_o, 32'h0);
        check({wb_ack_o, move_o, alarm_o, seg_o.go}, 32'h0);
        rst_i <= 1'b0;
        wb(1'b0, 10'h0FC, 32'h0, rd);
        check(rd, chain_seq_pkg::ENTRY_RST);
        set_entry(63, 1, 1, 3, 8'h11);
        wb(1'b0, 10'h0FC, 32'h0, rd);
        check(rd[15:0], 16'h0035);
        wb(1'b0, 10'h300, 32'h0, rd);
        check(rd, 32'h0);
        wb(1'b0, chain_seq_pkg::ADR_STAT, 32'h0, rd);
        check(rd[0], 32'h1);
        set_entry(0, 1, 1, 0, 0);
        set_entry(1, 0, 0, 0, 0);
        run(1);
        set_entry(2, 1, 1, 0, 0);
        set_entry(3, 1, 1, 0, 0);
        set_entry(4, 3, 1, 0, 8'h5A);
        run(2);
        for (int i = 10; i < 14; i++) set_entry(i, 1, 0, 0, 0);
        set_entry(14, 0, 0, 0, 0);
        run(10);
        run(11);
        set_entry(20, 1, 0, 0, 0);
        set_entry(21, 0, 1, 0, 0);
        run(20);
        run(63);
        set_entry(30, 2, 0, 2, 0);
        set_entry(31, 2, 1, 0, 0);
        set_entry(32, 1, 0, 0, 0);
        set_entry(33, 0, 0, 0, 0);
        run(30);
        final_report();
    end
endmodule : operation_data_chain_sequencer_tb
`default_nettype wire
